// *** cdfb_consts.svh ***
// Constants for the CAN diagnostic flag bank
`ifndef CDFB_CONSTS_SVH
`define CDFB_CONSTS_SVH

// ================================================================
// Flag positions in the response word
`define CDFB_NUM_FLAGS 15
`define CDFB_NUM_RT 3
`define CDFB_RESP_W 18
`define CDFB_BIT_WAKE 0
`define CDFB_BIT_OVERTEMP 1
`define CDFB_BIT_RX_LOW 2
`define CDFB_BIT_RX_HIGH 3
`define CDFB_BIT_TX_DOM 4
`define CDFB_BIT_BUS_DOM 5
`define CDFB_BIT_OVERCUR 6
`define CDFB_BIT_SUSPECT 7
`define CDFB_BIT_CONFIRM 8
`define CDFB_BIT_CANL_BAT 9
`define CDFB_BIT_CANL_VDD 10
`define CDFB_BIT_CANL_GND 11
`define CDFB_BIT_CANH_BAT 12
`define CDFB_BIT_CANH_VDD 13
`define CDFB_BIT_CANH_GND 14
`define CDFB_FLAGS_RESET 15'h0000
`define CDFB_RESP_RESET 18'h00000
// Read command code for the CAN flag group
`define CDFB_READ_CMD 16'h2180

`endif

// *** cdfb_pkg.sv ***
// Types for the CAN diagnostic flag bank
`default_nettype none

package cdfb_pkg;
  typedef logic [14:0] cdfb_flags_t;
  typedef logic [15:0] cdfb_cmd_t;
  typedef logic [17:0] cdfb_resp_t;
endpackage : cdfb_pkg

`default_nettype wire

// *** cdfb_flag_bank.sv ***
// Latched CAN diagnostic flags with read-to-clear once the condition is gone
`include "cdfb_consts.svh"
`default_nettype none

module cdfb_flag_bank
  import cdfb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Detector levels, one per flag, high while the condition stands
  input wire logic wake_event,
  input wire logic overtemp_det,
  input wire logic rx_low_det,
  input wire logic rx_high_det,
  input wire logic tx_dom_det,
  input wire logic bus_dom_det,
  input wire logic overcur_det,
  input wire logic bus_fault_suspect_det,
  input wire logic bus_fault_confirm_det,
  input wire logic canl_bat_det,
  input wire logic canl_vdd_det,
  input wire logic canl_gnd_det,
  input wire logic canh_bat_det,
  input wire logic canh_vdd_det,
  input wire logic canh_gnd_det,
  // Real-time state bits
  input wire logic driver_enabled,
  input wire logic receiver_enabled,
  input wire logic wake_rx_enabled,
  // Read command from the serial front end
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  // Response and live flag view
  output logic resp_valid,
  output logic [17:0] resp_data,
  output logic [14:0] flags
);

  // ================================================================
  // Internal signals
  // Command decode
  wire logic read_hit;
  // Per-flag terms
  wire cdfb_flags_t det;
  wire cdfb_flags_t set_now;
  wire cdfb_flags_t clr_ok;
  wire cdfb_flags_t read_seen;
  wire cdfb_flags_t pend_arm;
  wire cdfb_flags_t pend_keep;
  cdfb_flags_t read_pend;
  cdfb_flags_t next_flags;
  cdfb_flags_t next_pend;
  // Response path
  wire logic [2:0] live_state;
  wire cdfb_resp_t snapshot;
  wire logic next_resp_valid;
  wire cdfb_resp_t next_resp_data;

  // ================================================================
  // Command decode

  assign read_hit = cmd_valid && (cmd_code == `CDFB_READ_CMD);

  // ================================================================
  // Detector gather
  // Wake and thermal
  assign det[`CDFB_BIT_WAKE] = wake_event;
  assign det[`CDFB_BIT_OVERTEMP] = overtemp_det;

  // Pin faults
  assign det[`CDFB_BIT_RX_LOW] = rx_low_det;
  assign det[`CDFB_BIT_RX_HIGH] = rx_high_det;
  assign det[`CDFB_BIT_TX_DOM] = tx_dom_det;

  // Bus-level faults
  assign det[`CDFB_BIT_BUS_DOM] = bus_dom_det;
  assign det[`CDFB_BIT_OVERCUR] = overcur_det;
  assign det[`CDFB_BIT_SUSPECT] = bus_fault_suspect_det;
  assign det[`CDFB_BIT_CONFIRM] = bus_fault_confirm_det;

  // Line shorts
  assign det[`CDFB_BIT_CANL_BAT] = canl_bat_det;
  assign det[`CDFB_BIT_CANL_VDD] = canl_vdd_det;
  assign det[`CDFB_BIT_CANL_GND] = canl_gnd_det;
  assign det[`CDFB_BIT_CANH_BAT] = canh_bat_det;
  assign det[`CDFB_BIT_CANH_VDD] = canh_vdd_det;
  assign det[`CDFB_BIT_CANH_GND] = canh_gnd_det;

  // ================================================================
  // Per-flag set and clear
  // A read that finds a level condition still present is remembered, so the flag
  // drops as soon as the condition goes without needing a second read.
  genvar gi;
  generate
    for (gi = 0; gi < `CDFB_NUM_FLAGS; gi = gi + 1)
    begin : g_flag
      // Only a read that returned this flag as set may arm its later clear
      assign read_seen[gi] = read_hit & flags[gi];
      assign set_now[gi] = det[gi];
      // Wake is event-only: a read alone clears it
      if (gi == `CDFB_BIT_WAKE)
      begin : g_evt
        assign clr_ok[gi] = read_hit;
        assign pend_arm[gi] = 1'b0;
        assign pend_keep[gi] = 1'b0;
      end
      else
      begin : g_lvl
        // Recovery is the detector going low; the read may come first
        assign clr_ok[gi] = (read_hit || read_pend[gi]) && !det[gi];
        assign pend_arm[gi] = read_seen[gi] & det[gi];
        assign pend_keep[gi] = read_pend[gi] & det[gi];
      end
      // Set wins over clear, so an event during the read stays latched
      assign next_flags[gi] = set_now[gi] | (flags[gi] & ~clr_ok[gi]);
      assign next_pend[gi] = next_flags[gi] & (pend_arm[gi] | pend_keep[gi]);
    end
  endgenerate

  // ================================================================
  // Response assembly
  // Real-time bits come straight from their sources and a read never touches them
  assign live_state = {wake_rx_enabled, receiver_enabled, driver_enabled};
  // Registered flags are the values before this read clears anything
  assign snapshot = {live_state, flags};
  assign next_resp_valid = read_hit;
  // The word stands until the next read, so the host may fetch it late
  assign next_resp_data = read_hit ? snapshot : resp_data;

  // ================================================================
  // Flag registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      flags <= `CDFB_FLAGS_RESET;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  // Pending clears go with reset, so a stale read cannot clear a fresh fault
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      read_pend <= `CDFB_FLAGS_RESET;
    end
    else
    begin
      read_pend <= next_pend;
    end
  end

  // ================================================================
  // Response registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resp_valid <= 1'b0;
    end
    else
    begin
      resp_valid <= next_resp_valid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      resp_data <= `CDFB_RESP_RESET;
    end
    else
    begin
      resp_data <= next_resp_data;
    end
  end

endmodule : cdfb_flag_bank

`default_nettype wire

// *** cdfb_host_model.sv ***
// Host model that issues flag-group reads to the bank
`default_nettype none
module cdfb_host_model (
  // Bench request in, command out
  input wire logic clk,
  input wire logic go,
  input wire logic [15:0] code,
  output logic cmd_valid,
  output logic [15:0] cmd_code
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle code shows the inverse, never a stale command
  always_ff @(posedge clk) {cmd_valid, cmd_code} <= {go, go ? code : ~code};
endmodule : cdfb_host_model
`default_nettype wire

// *** cdfb_flag_bank_chk.sv ***
// Assertion checker for the CAN diagnostic flag bank
`include "cdfb_consts.svh"
`default_nettype none
module cdfb_flag_bank_chk (
  // Watched ports
  input wire logic clk,
  input wire logic reset,
  input wire logic wake_event,
  input wire logic overtemp_det,
  input wire logic driver_enabled,
  input wire logic receiver_enabled,
  input wire logic wake_rx_enabled,
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_code,
  input wire logic resp_valid,
  input wire logic [17:0] resp_data,
  input wire logic [14:0] flags
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic rd = cmd_valid && cmd_code == `CDFB_READ_CMD;
  wire logic [2:0] live = {wake_rx_enabled, receiver_enabled, driver_enabled};
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_reply_due: assert property (rd |=> resp_valid) else $error("reply missing");
  a_reply_only: assert property (!rd |=> !resp_valid) else $error("stray reply");
  a_reply_hold: assert property (!rd |=> $stable(resp_data)) else $error("reply moved");
  a_reply_snap: assert property (rd |=> resp_data[14:0] == $past(flags)) else $error("bad snapshot");
  a_temp_set: assert property (overtemp_det |=> flags[1]) else $error("temp not set");
  a_temp_cause: assert property ($rose(flags[1]) |-> $past(overtemp_det)) else $error("temp no cause");
  a_temp_clear: assert property (rd && !overtemp_det |=> !flags[1]) else $error("temp kept");
  a_temp_quiet: assert property (!flags[1] && !overtemp_det |=> !flags[1]) else $error("temp rose");
  a_wake_clear: assert property (rd && !wake_event |=> !flags[0]) else $error("wake kept");
  a_live_pass: assert property (rd |=> resp_data[17:15] == $past(live)) else $error("live bits lost");
  cover property (rd && flags[1]);
  cover property (rd && overtemp_det && flags[1]);
  cover property (rd && flags[14]);
  cover property (resp_valid && resp_data[0]);
endmodule : cdfb_flag_bank_chk
bind cdfb_flag_bank cdfb_flag_bank_chk u_chk (.*);
`default_nettype wire

// *** cdfb_flag_bank_tb.sv ***
// Self-checking bench for the CAN diagnostic flag bank
`default_nettype none
module cdfb_flag_bank_tb import cdfb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'h0, reset = 1'h1, go = 1'h0;
  logic [15:0] code = 16'h2180;
  cdfb_flags_t det = 15'h0;
  logic [2:0] live = 3'h5;
  wire logic cmd_valid, resp_valid;
  wire logic [15:0] cmd_code;
  wire cdfb_resp_t resp_data;
  wire cdfb_flags_t flags;
  int fails = 0, total_checks = 0, cycles = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cycles == 1000) test_done(1);
  cdfb_host_model host (.*);
  cdfb_flag_bank dut (.*, .wake_event(det[0]), .overtemp_det(det[1]), .rx_low_det(det[2]), .rx_high_det(det[3]),
    .tx_dom_det(det[4]), .bus_dom_det(det[5]), .overcur_det(det[6]), .bus_fault_suspect_det(det[7]),
    .bus_fault_confirm_det(det[8]), .canl_bat_det(det[9]), .canl_vdd_det(det[10]), .canl_gnd_det(det[11]),
    .canh_bat_det(det[12]), .canh_vdd_det(det[13]), .canh_gnd_det(det[14]), .driver_enabled(live[0]),
    .receiver_enabled(live[1]), .wake_rx_enabled(live[2]));
  task automatic check(input string what, input cdfb_resp_t seen, want);
    total_checks++;
    fails += int'(seen !== want);
    if (seen !== want) $display("[FAIL] %s expected %h seen %h", what, want, seen);
  endtask : check
  task automatic rd(input logic [15:0] c);
    @(posedge clk) {go, code} <= {1'h1, c};
    @(posedge clk) go <= 1'h0;
    @(posedge clk) #1;
  endtask : rd
  // Each flag outlives its cause and a foreign code, then one real read clears it
  task automatic t_each_flag;
    for (int i = 0; i < 15; i++)
    begin
      @(posedge clk) det <= 15'h1 << i;
      repeat (2) @(posedge clk);
      det <= 15'h0;
      rd(16'h2181);
      check("kept", 18'({resp_valid, flags}), 18'(15'h1 << i));
      rd(16'h2180);
      check("reply", resp_data, {live, 15'h1 << i});
      check("valid", 18'(resp_valid), 18'h00001);
      check("clear", 18'(flags), 18'h0);
    end
  endtask : t_each_flag
  // A read while the cause stands keeps a level flag, which then drops on recovery alone
  task automatic t_read_active;
    @(posedge clk) det <= 15'h0003;
    rd(16'h2180);
    check("busy reply", resp_data, {live, 15'h0003});
    check("busy kept", 18'(flags), 18'h00003);
    @(posedge clk) det <= 15'h0;
    @(posedge clk) #1;
    check("recovered", 18'(flags), 18'h00001);
    rd(16'h2180);
    check("wake reply", resp_data, {live, 15'h0001});
    check("wake clear", 18'(flags), 18'h0);
  endtask : t_read_active
  // An event on the read edge stays latched for the next read; live bits follow their pins
  task automatic t_event_in_read;
    @(posedge clk) {go, code, live} <= {1'h1, 16'h2180, 3'h2};
    @(posedge clk) {go, det} <= {1'h0, 15'h4000};
    @(posedge clk) det <= 15'h0;
    #1;
    check("edge reply", resp_data, {3'h2, 15'h0});
    check("edge kept", 18'(flags), 18'h04000);
    rd(16'h2180);
    check("edge next", resp_data, {3'h2, 15'h4000});
    check("edge clear", 18'(flags), 18'h0);
  endtask : t_event_in_read
  // A reset in mid-run drops flags, the reply word and any remembered read
  task automatic t_mid_reset;
    @(posedge clk) det <= 15'h0100;
    rd(16'h2180);
    check("pend reply", resp_data, {live, 15'h0100});
    @(posedge clk) reset <= 1'h1;
    @(posedge clk) #1;
    check("reset flags", 18'({resp_valid, flags}), 18'h0);
    check("reset reply", resp_data, 18'h0);
    @(posedge clk) reset <= 1'h0;
    @(posedge clk) det <= 15'h0;
    @(posedge clk) #1;
    check("reset pend", 18'(flags), 18'h00100);
    rd(16'h2180);
    check("reset clear", 18'(flags), 18'h0);
  endtask : t_mid_reset
  task automatic test_done(input int extra);
    fails += extra;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    t_each_flag();
    t_read_active();
    t_event_in_read();
    t_mid_reset();
    test_done(0);
  end
endmodule : cdfb_flag_bank_tb
`default_nettype wire
